// File: design/kfc_pkg.sv
// Purpose: Shared constants and types of the keypad and fan command handler.
// Assumes: 20 MHz system clock; host packets arrive already framed and checked.
// Notes on behaviour
// - By default report every press and release.
// - Type 0x17 sets press, release masks; ack 0x57.
// - Key masks are saved and restored as boot state.
// - Type 0x18 replies 0x58 with three key bytes.
// - Key bits: up, confirm, abort, west, east, south.
// - Type 0x19 sets fan mask, eighth-second timeout; ack 0x59.
// - Fan one to four are bits 0 to 3.
// - Timeout forces fail-safe fans to full power.
// - Fans run PWM at about 18 Hz.
// - Tachometer ignored for delay counts after turn-on.
// - Glitch delay resets to one count.
// - Type 0x1A sets four delays; ack 0x5A.
// - Glitch delays are saved as boot state.
// - Zero-power fan with RPM enabled still pulses briefly.
// - Type 0x1B replies 0x5B with powers and mask.
package kfc_pkg;

   // Clock and timing.
   localparam real         CLK_PERIOD_NS      = 50.0;
   localparam real         GLITCH_COUNT_US    = 552.5;
   localparam int unsigned GLITCH_COUNT_CYC   = int'($floor(GLITCH_COUNT_US * 1000.0 / CLK_PERIOD_NS));
   localparam real         FS_TICK_MS         = 125.0;
   localparam int unsigned FS_TICK_CYC        = int'($floor(FS_TICK_MS * 1.0e6 / CLK_PERIOD_NS));
   localparam int unsigned PWM_STEPS          = 100;
   localparam logic [7:0]  FAN_MEAS_COUNTS    = 8'h04;

   // Command and reply codes.
   localparam logic [7:0]  CMD_KEY_CFG        = 8'h17;
   localparam logic [7:0]  CMD_KEY_POLL       = 8'h18;
   localparam logic [7:0]  CMD_FAILSAFE       = 8'h19;
   localparam logic [7:0]  CMD_GLITCH         = 8'h1a;
   localparam logic [7:0]  CMD_FAN_QUERY      = 8'h1b;
   localparam logic [7:0]  RSP_FLAG           = 8'h40;

   // Key bit assignment.
   localparam logic [5:0]  key_up_bit         = 6'h01;
   localparam logic [5:0]  key_confirm_bit    = 6'h02;
   localparam logic [5:0]  key_abort_bit      = 6'h04;
   localparam logic [5:0]  key_west_bit       = 6'h08;
   localparam logic [5:0]  key_east_bit       = 6'h10;
   localparam logic [5:0]  key_south_bit      = 6'h20;
   localparam logic [5:0]  KEY_ALL            = 6'h3f;

   // Reset values and full fan power.
   localparam logic [7:0]  GLITCH_RST         = 8'h01;
   localparam logic [7:0]  FAN_POWER_RST      = 8'h00;
   localparam logic [7:0]  FAN_FULL           = 8'h64;

   // Boot store layout.
   localparam logic [2:0]  BOOT_PRESS_IDX     = 3'h0;
   localparam logic [2:0]  BOOT_RELEASE_IDX   = 3'h1;
   localparam logic [2:0]  BOOT_GLITCH_IDX    = 3'h2;
   localparam logic [2:0]  BOOT_WORDS         = 3'h6;

   typedef struct packed {
      logic            valid;
      logic [7:0]      ctype;
      logic [2:0]      len;
      logic [3:0][7:0] data;
   } kfc_cmd_t;

   typedef struct packed {
      logic            valid;
      logic [7:0]      rtype;
      logic [2:0]      len;
      logic [4:0][7:0] data;
   } kfc_rsp_t;

   typedef struct packed {
      logic       valid;
      logic [5:0] press;
      logic [5:0] release_keys;
   } kfc_key_evt_t;

   typedef enum logic [1:0] {KFC_INIT, KFC_RESTORE, KFC_RUN, KFC_SAVE} kfc_mode_t;

endpackage

// File: design/kfc_boot_mem.sv
// Purpose: Small store for the boot configuration words.
// Assumes: Contents survive reset; only the read register is reset.
// Notes: Read data appear one cycle after the address.
`timescale 1ns/1ps
`default_nettype none
module kfc_boot_mem #(
   parameter int unsigned DEPTH = 8,
   parameter int unsigned WIDTH = 8
) (
   // Clock and reset.
   input  wire logic                     clk_in,
   input  wire logic                     nrst_in,
   // Write port.
   input  wire logic                     wr_in,
   input  wire logic [$clog2(DEPTH)-1:0] waddr_in,
   input  wire logic [WIDTH-1:0]         wdata_in,
   // Read port.
   input  wire logic [$clog2(DEPTH)-1:0] raddr_in,
   output var  logic [WIDTH-1:0]         rdata_out
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Storage array, never cleared so that saved words outlive a reset.
   always_ff @(posedge clk_in) begin
      if (wr_in) begin
         mem[waddr_in] <= wdata_in;
      end
   end

   // Registered read data.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         rdata_out <= '0;
      end else begin
         rdata_out <= mem[raddr_in];
      end
   end
endmodule
`default_nettype wire

// File: design/kfc_fan_chan.sv
// Purpose: One fan channel: PWM drive and blanked tachometer edge detection.
// Assumes: tick_in pulses once per glitch count, one hundredth of a PWM period.
// Notes: Tachometer pin is synchronised here.
`timescale 1ns/1ps
`default_nettype none
module kfc_fan_chan
   import kfc_pkg::*;
#(
   parameter int unsigned STEPS = kfc_pkg::PWM_STEPS
) (
   // Clock and reset.
   input  wire logic       clk_in,
   input  wire logic       nrst_in,
   // Control.
   input  wire logic       tick_in,
   input  wire logic [7:0] power_in,
   input  wire logic [7:0] delay_in,
   input  wire logic       rpm_en_in,
   // Fan pins and result.
   input  wire logic       tach_pin_in,
   output var  logic       pwm_out,
   output var  logic       tach_edge_out
);
   typedef struct packed {
      logic       meta;
      logic       sync;
      logic       prev;
      logic [7:0] phase;
      logic [7:0] blank;
      logic       pwm;
      logic       edge_seen;
   } kfc_chan_state_t;

   kfc_chan_state_t st_reg;
   kfc_chan_state_t st_next;

   // PWM phase, turn-on blanking and edge qualification.
   always_comb begin
      logic [7:0] ph;
      logic [8:0] meas_end;
      logic       on_lvl;
      ph       = st_reg.phase;
      meas_end = {1'b0, delay_in} + {1'b0, FAN_MEAS_COUNTS};
      on_lvl   = 1'b0;
      st_next  = st_reg;
      st_next.meta      = tach_pin_in;
      st_next.sync      = st_reg.meta;
      st_next.prev      = st_reg.sync;
      st_next.edge_seen = 1'b0;
      if (tick_in) begin
         ph = (st_reg.phase == 8'(STEPS - 1)) ? 8'h00 : st_reg.phase + 8'h01;
         on_lvl = (power_in >= 8'(STEPS)) || (ph < power_in) ||
                  (rpm_en_in && power_in == 8'h00 && {1'b0, ph} < meas_end);
         st_next.phase = ph;
         st_next.pwm   = on_lvl;
         if (on_lvl && !st_reg.pwm) begin
            st_next.blank = delay_in;
         end else if (st_reg.blank != 8'h00) begin
            st_next.blank = st_reg.blank - 8'h01;
         end
      end
      if (st_reg.pwm && st_reg.blank == 8'h00 && st_reg.sync != st_reg.prev) begin
         st_next.edge_seen = 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pwm_out       = st_reg.pwm;
   assign tach_edge_out = st_reg.edge_seen;
endmodule
`default_nettype wire

// File: design/kfc_handler.sv
// Purpose: Keypad reporting, polled keypad reads and fan supervision commands.
// Assumes: Command words come from logic on clk_in; key and tach pins are asynchronous.
// Notes: Commands are taken only while cmd_ready_out is high.
`timescale 1ns/1ps
`default_nettype none
module kfc_handler
   import kfc_pkg::*;
#(
   parameter int unsigned COUNT_CYC = kfc_pkg::GLITCH_COUNT_CYC,
   parameter int unsigned FS_CYC    = kfc_pkg::FS_TICK_CYC,
   parameter int unsigned FANS      = 4
) (
   // Clock and reset.
   input  wire logic                   clk_in,
   input  wire logic                   nrst_in,
   // Host command and reply.
   input  wire kfc_pkg::kfc_cmd_t      cmd_in,
   output var  logic                   cmd_ready_out,
   output var  logic                   cmd_err_out,
   output var  kfc_pkg::kfc_rsp_t      rsp_out,
   // Key pins and event reports.
   input  wire logic [5:0]             key_pin_in,
   output var  kfc_pkg::kfc_key_evt_t  key_evt_out,
   // Fan power updates from the host.
   input  wire logic [FANS-1:0]        fan_pwr_wr_in,
   input  wire logic [7:0]             fan_pwr_val_in,
   input  wire logic [FANS-1:0]        rpm_en_in,
   // Boot configuration control.
   input  wire logic                   boot_valid_in,
   input  wire logic                   save_boot_in,
   // Fan pins and tachometer results.
   input  wire logic [FANS-1:0]        tach_pin_in,
   output var  logic [FANS-1:0]        fan_pwm_out,
   output var  logic [FANS-1:0]        tach_edge_out,
   output var  logic [FANS-1:0]        fan_forced_out
);
   localparam int unsigned CW = $clog2(COUNT_CYC + 1);
   localparam int unsigned FW = $clog2(FS_CYC + 1);

   typedef struct packed {
      kfc_mode_t             mode;
      logic [2:0]            idx;
      logic [5:0]            key_meta;
      logic [5:0]            held;
      logic [5:0]            key_prev;
      logic                  boot_meta;
      logic                  boot_sync;
      logic [5:0]            press_mask;
      logic [5:0]            release_mask;
      logic [5:0]            pressed_acc;
      logic [5:0]            released_acc;
      logic [FANS-1:0][7:0]  glitch;
      logic [FANS-1:0][7:0]  power;
      logic [FANS-1:0]       fs_mask;
      logic [FANS-1:0]       forced;
      logic [7:0]            fs_timeout;
      logic [7:0]            fs_cnt;
      logic [FW-1:0]         fs_div;
      logic [CW-1:0]         cnt_div;
      logic                  cnt_tick;
      logic                  fs_tick;
      kfc_rsp_t              rsp;
      kfc_key_evt_t          evt;
      logic                  err;
      logic                  ready;
   } kfc_top_state_t;

   kfc_top_state_t st_reg;
   kfc_top_state_t st_next;
   logic [7:0]     boot_rdata;
   logic           boot_wr;

   // Configuration word kept at a given boot store index.
   function automatic logic [7:0] cfg_word(input kfc_top_state_t s, input logic [2:0] i);
      logic [7:0] w;
      w = 8'h00;
      case (i)
         BOOT_PRESS_IDX:   w = {2'b00, s.press_mask};
         BOOT_RELEASE_IDX: w = {2'b00, s.release_mask};
         default:          w = s.glitch[2'(i - BOOT_GLITCH_IDX)];
      endcase
      return w;
   endfunction

   // Check a command for a legal length and legal field values.
   function automatic logic cmd_ok(input kfc_cmd_t c);
      logic ok;
      ok = 1'b0;
      case (c.ctype)
         CMD_KEY_CFG:   ok = (c.len == 3'd2);
         CMD_KEY_POLL:  ok = (c.len == 3'd0);
         CMD_FAILSAFE:  ok = (c.len == 3'd2) && (c.data[0][7:4] == 4'h0) &&
                             (c.data[0][3:0] != 4'h0) && (c.data[1] != 8'h00);
         CMD_GLITCH:    ok = (c.len == 3'd4);
         CMD_FAN_QUERY: ok = (c.len == 3'd0);
         default:       ok = 1'b0;
      endcase
      return ok;
   endfunction

   // Boot configuration store.
   kfc_boot_mem #(
      .DEPTH (8),
      .WIDTH (8)
   ) u_boot (
      .clk_in    (clk_in),
      .nrst_in   (nrst_in),
      .wr_in     (boot_wr),
      .waddr_in  (st_reg.idx),
      .wdata_in  (cfg_word(st_reg, st_reg.idx)),
      .raddr_in  (st_reg.idx),
      .rdata_out (boot_rdata)
   );

   assign boot_wr = (st_reg.mode == KFC_SAVE) && (st_reg.idx < BOOT_WORDS);

   // Fan channels.
   genvar gi;
   generate
      for (gi = 0; gi < FANS; gi++) begin : g_fan
         kfc_fan_chan #(
            .STEPS (PWM_STEPS)
         ) u_chan (
            .clk_in        (clk_in),
            .nrst_in       (nrst_in),
            .tick_in       (st_reg.cnt_tick),
            .power_in      (st_reg.power[gi]),
            .delay_in      (st_reg.glitch[gi]),
            .rpm_en_in     (rpm_en_in[gi]),
            .tach_pin_in   (tach_pin_in[gi]),
            .pwm_out       (fan_pwm_out[gi]),
            .tach_edge_out (tach_edge_out[gi])
         );
      end
   endgenerate

   // Next-state logic for keys, commands, boot sequencing and fail-safe.
   always_comb begin
      logic [5:0] rise;
      logic [5:0] fall;
      logic       take;
      logic       pwr_upd;
      logic       fs_load;
      fs_load = 1'b0;
      st_next = st_reg;
      st_next.rsp.valid = 1'b0;
      st_next.evt.valid = 1'b0;
      st_next.err       = 1'b0;
      st_next.cnt_tick  = 1'b0;
      st_next.fs_tick   = 1'b0;

      // Pin synchronisers; held is the second stage.
      st_next.key_meta  = key_pin_in;
      st_next.held      = st_reg.key_meta;
      st_next.boot_meta = boot_valid_in;
      st_next.boot_sync = st_reg.boot_meta;
      st_next.key_prev  = st_reg.held;
      rise = st_reg.held & ~st_reg.key_prev;
      fall = ~st_reg.held & st_reg.key_prev;
      // Glitch count and eighth-second dividers.
      if (st_reg.cnt_div == CW'(COUNT_CYC - 1)) begin
         st_next.cnt_div  = '0;
         st_next.cnt_tick = 1'b1;
      end else begin
         st_next.cnt_div = st_reg.cnt_div + CW'(1);
      end
      if (st_reg.fs_div == FW'(FS_CYC - 1)) begin
         st_next.fs_div  = '0;
         st_next.fs_tick = 1'b1;
      end else begin
         st_next.fs_div = st_reg.fs_div + FW'(1);
      end
      // Unsolicited key reports, gated by the masks.
      if (((rise & st_reg.press_mask) | (fall & st_reg.release_mask)) != 6'h00) begin
         st_next.evt.valid        = 1'b1;
         st_next.evt.press        = rise & st_reg.press_mask;
         st_next.evt.release_keys = fall & st_reg.release_mask;
      end

      // Poll accumulators see every key; new edges win over a poll clear.
      st_next.pressed_acc  = st_reg.pressed_acc | rise;
      st_next.released_acc = st_reg.released_acc | fall;

      take = (st_reg.mode == KFC_RUN) && cmd_in.valid;
      if (take && !cmd_ok(cmd_in)) begin
         st_next.err = 1'b1;
      end else if (take) begin
         st_next.rsp.valid = 1'b1;
         st_next.rsp.rtype = cmd_in.ctype | RSP_FLAG;
         st_next.rsp.len   = 3'd0;
         st_next.rsp.data  = '0;
         case (cmd_in.ctype)
            CMD_KEY_CFG: begin
               st_next.press_mask   = cmd_in.data[0][5:0];
               st_next.release_mask = cmd_in.data[1][5:0];
            end
            CMD_KEY_POLL: begin
               st_next.rsp.len     = 3'd3;
               st_next.rsp.data[0] = {2'b00, st_reg.held};
               st_next.rsp.data[1] = {2'b00, st_reg.pressed_acc};
               st_next.rsp.data[2] = {2'b00, st_reg.released_acc};
               st_next.pressed_acc  = rise;
               st_next.released_acc = fall;
            end
            CMD_FAILSAFE: begin
               st_next.fs_mask    = cmd_in.data[0][FANS-1:0];
               st_next.fs_timeout = cmd_in.data[1];
               st_next.fs_cnt     = cmd_in.data[1];
               fs_load            = 1'b1;
            end
            CMD_GLITCH: begin
               st_next.glitch = cmd_in.data;
            end
            CMD_FAN_QUERY: begin
               st_next.rsp.len     = 3'd5;
               st_next.rsp.data[3:0] = st_reg.power;
               st_next.rsp.data[4] = {4'h0, st_reg.fs_mask};
            end
            default: begin
               st_next.rsp.valid = 1'b0;
            end
         endcase
      end
      // Host power updates and the fail-safe countdown; a new fail-safe command wins.
      pwr_upd = (fan_pwr_wr_in != '0);
      for (int f = 0; f < FANS; f++) begin
         if (fan_pwr_wr_in[f]) begin
            st_next.power[f]  = fan_pwr_val_in;
            st_next.forced[f] = 1'b0;
         end
      end
      if (pwr_upd) begin
         st_next.fs_cnt = st_next.fs_timeout;
      end else if (st_reg.fs_tick && st_reg.fs_cnt != 8'h00 && !fs_load) begin
         st_next.fs_cnt = st_reg.fs_cnt - 8'h01;
         if (st_reg.fs_cnt == 8'h01) begin
            for (int f = 0; f < FANS; f++) begin
               if (st_reg.fs_mask[f]) begin
                  st_next.power[f]  = FAN_FULL;
                  st_next.forced[f] = 1'b1;
               end
            end
         end
      end
      // Boot configuration sequencing.
      case (st_reg.mode)
         KFC_INIT: begin
            st_next.idx = st_reg.idx + 3'd1;
            if (st_reg.idx == 3'd2) begin
               st_next.idx  = 3'd0;
               st_next.mode = st_reg.boot_sync ? KFC_RESTORE : KFC_RUN;
            end
         end
         KFC_RESTORE: begin
            st_next.idx = st_reg.idx + 3'd1;
            if (st_reg.idx != 3'd0) begin
               case (3'(st_reg.idx - 3'd1))
                  BOOT_PRESS_IDX:   st_next.press_mask = boot_rdata[5:0];
                  BOOT_RELEASE_IDX: st_next.release_mask = boot_rdata[5:0];
                  default:          st_next.glitch[2'(st_reg.idx - 3'd3)] = boot_rdata;
               endcase
            end
            if (st_reg.idx == BOOT_WORDS) begin
               st_next.idx  = 3'd0;
               st_next.mode = KFC_RUN;
            end
         end
         KFC_RUN: begin
            if (save_boot_in && !cmd_in.valid) begin
               st_next.idx  = 3'd0;
               st_next.mode = KFC_SAVE;
            end
         end
         KFC_SAVE: begin
            st_next.idx = st_reg.idx + 3'd1;
            if (st_reg.idx == BOOT_WORDS - 3'd1) begin
               st_next.idx  = 3'd0;
               st_next.mode = KFC_RUN;
            end
         end
         default: begin
            st_next.mode = KFC_RUN;
         end
      endcase
      st_next.ready = (st_next.mode == KFC_RUN); // Ready output comes from a flop.
   end

   // State register with documented defaults.
   always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_reg              <= '0;
         st_reg.mode         <= KFC_INIT;
         st_reg.press_mask   <= KEY_ALL;
         st_reg.release_mask <= KEY_ALL;
         st_reg.glitch       <= {FANS{GLITCH_RST}};
         st_reg.power        <= {FANS{FAN_POWER_RST}};
      end else begin
         st_reg <= st_next;
      end
   end

   assign cmd_ready_out  = st_reg.ready;
   assign cmd_err_out    = st_reg.err;
   assign rsp_out        = st_reg.rsp;
   assign key_evt_out    = st_reg.evt;
   assign fan_forced_out = st_reg.forced;

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   sequence key_cfg_cmd_s;
      cmd_ready_out && cmd_in.valid && cmd_in.ctype == CMD_KEY_CFG && cmd_in.len == 3'd2;
   endsequence
   sequence poll_cmd_s;
      cmd_ready_out && cmd_in.valid && cmd_in.ctype == CMD_KEY_POLL && cmd_in.len == 3'd0;
   endsequence
   sequence expire_s;
      st_reg.fs_tick && st_reg.fs_cnt == 8'h01 && fan_pwr_wr_in == '0;
   endsequence

   key_cfg_ack_a: assert property (key_cfg_cmd_s |=> rsp_out.valid && rsp_out.rtype == 8'h57
      && rsp_out.len == 3'd0 && st_reg.press_mask == $past(cmd_in.data[0][5:0]))
      else $error("Key config not taken or not acknowledged.");
   poll_reply_a: assert property (poll_cmd_s |=> rsp_out.valid && rsp_out.rtype == 8'h58
      && rsp_out.len == 3'd3 && rsp_out.data[1] == {2'b00, $past(st_reg.pressed_acc)})
      else $error("Poll reply wrong.");
   poll_clear_a: assert property (poll_cmd_s ##0 (st_reg.held == st_reg.key_prev)
      |=> st_reg.pressed_acc == 6'h00 && st_reg.released_acc == 6'h00)
      else $error("Poll did not clear accumulators.");
   evt_gate_a: assert property (key_evt_out.valid |->
      (key_evt_out.press & ~$past(st_reg.press_mask)) == 6'h00)
      else $error("Masked key event reported.");
   failsafe_ack_a: assert property (cmd_ready_out && cmd_in.valid && cmd_in.ctype == CMD_FAILSAFE
      && cmd_in.len == 3'd2 && cmd_in.data[0] == 8'h05 && cmd_in.data[1] == 8'h03
      |=> rsp_out.rtype == 8'h59 && st_reg.fs_cnt == 8'h03 && st_reg.fs_mask == 4'h5)
      else $error("Fail-safe command not taken.");
   failsafe_force_a: assert property (expire_s ##0 (st_reg.fs_mask[0] && !cmd_in.valid)
      |=> st_reg.power[0] == FAN_FULL ##1 fan_forced_out[0])
      else $error("Fail-safe fan not forced to full power.");
   unmasked_keep_a: assert property (expire_s ##0 !st_reg.fs_mask[1]
      |=> st_reg.power[1] == $past(st_reg.power[1]))
      else $error("Unmasked fan changed on timeout.");
   restart_cnt_a: assert property (fan_pwr_wr_in != '0 && !cmd_in.valid
      |=> st_reg.fs_cnt == $past(st_reg.fs_timeout))
      else $error("Power update did not restart countdown.");
   glitch_load_a: assert property (cmd_ready_out && cmd_in.valid && cmd_in.ctype == CMD_GLITCH
      && cmd_in.len == 3'd4 |=> rsp_out.rtype == 8'h5a && st_reg.glitch == $past(cmd_in.data))
      else $error("Glitch delays not loaded.");
   query_reply_a: assert property (cmd_ready_out && cmd_in.valid && cmd_in.ctype == CMD_FAN_QUERY
      && cmd_in.len == 3'd0 && fan_pwr_wr_in == '0 |=> rsp_out.len == 3'd5
      && rsp_out.data[4] == {4'h0, $past(st_reg.fs_mask)}
      && rsp_out.data[3:0] == $past(st_reg.power))
      else $error("Fan query reply wrong.");
endmodule
`default_nettype wire

// File: verification/kfc_host_model.sv
// Purpose: Host model that issues command words to the handler.
// Assumes: A command is held until the edge that samples ready high.
// Notes: Released data bytes are inverted so that stale values never match.
`timescale 1ns/1ps
`default_nettype none
module kfc_host_model
   import kfc_pkg::*;
(
   // Clock and handshake.
   input  wire logic              clk_in,
   input  wire logic              ready_in,
   // Command word.
   output var  kfc_pkg::kfc_cmd_t cmd_out
);
   initial cmd_out = '0;

   // Sends one command and returns just after the edge that took it.
   task automatic send(input logic [7:0] t, input logic [2:0] n, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge clk_in);
      #1;
      cmd_out.valid = 1'b1;
      cmd_out.ctype = t;
      cmd_out.len   = n;
      cmd_out.data  = d;
      while (ready_in !== 1'b1 && k < 50) begin
         k++;
         @(posedge clk_in);
         #1;
      end
      @(posedge clk_in);
      #1;
      cmd_out.valid = 1'b0;
      cmd_out.data  = ~cmd_out.data;
   endtask
endmodule
`default_nettype wire

// File: verification/kfc_handler_tb_top.sv
// Purpose: Self-checking bench for the keypad and fan command handler.
// Assumes: Counts are shortened so fail-safe ticks come every 20 cycles.
// Notes: Boot store control stays idle; fan four measures at zero power.
`timescale 1ns/1ps
`default_nettype none
module kfc_handler_tb_top;
   import kfc_pkg::*;
   logic         clk_in  = 1'b0;
   logic         nrst_in = 1'b0;
   logic [5:0]   keys    = '0;
   logic [3:0]   pwr_wr  = '0;
   logic [7:0]   pwr_val = '0;
   logic [3:0]   rpm_en  = 4'h8;
   logic [3:0]   tach    = '0;
   logic [3:0]   tedge;
   int           tach_hits = 0;
   int           pwm3_hi = 0;
   int           n0 = 0;
   logic         rdy, err;
   logic [3:0]   pwm, forced;
   kfc_cmd_t     cmd;
   kfc_rsp_t     rsp;
   kfc_key_evt_t evt;
   int           error_cnt = 0;
   int           comparisons = 0;
   int           cyc = 0;

   // Clock and hang guard.
   always #25 clk_in = ~clk_in;
   always @(posedge clk_in) if (++cyc > 5000) begin
      error_cnt++;
      stop_test();
   end

   // Counts accepted tachometer edges of fan one and on cycles of fan four.
   always @(negedge clk_in) begin
      tach_hits += (tedge[0] === 1'b1);
      pwm3_hi   += (pwm[3] === 1'b1);
   end

   kfc_handler #(.COUNT_CYC(4), .FS_CYC(20)) dut_u (
      .clk_in(clk_in), .nrst_in(nrst_in), .cmd_in(cmd), .cmd_ready_out(rdy),
      .cmd_err_out(err), .rsp_out(rsp), .key_pin_in(keys), .key_evt_out(evt),
      .fan_pwr_wr_in(pwr_wr), .fan_pwr_val_in(pwr_val), .rpm_en_in(rpm_en),
      .boot_valid_in(1'b0), .save_boot_in(1'b0), .tach_pin_in(tach),
      .fan_pwm_out(pwm), .tach_edge_out(tedge), .fan_forced_out(forced));
   kfc_host_model host_u (.clk_in(clk_in), .ready_in(rdy), .cmd_out(cmd));

   // Prints the verdict and ends the run.
   task automatic stop_test();
      if (error_cnt == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // Compares one value and reports a mismatch.
   task automatic chk(input string nm, input logic [39:0] seen, input logic [39:0] exp);
      comparisons++;
      if (seen !== exp) begin
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
         error_cnt++;
      end
   endtask

   // Sends a command and checks its reply; a zero reply type expects refusal.
   task automatic xfer(input logic [7:0] t, input logic [2:0] n, input logic [31:0] d,
                       input logic [7:0] rt, input logic [2:0] rl, input logic [39:0] rd);
      host_u.send(t, n, d);
      chk("flags", {rsp.valid, err}, {rt != 8'h00, rt == 8'h00});
      if (rt != 8'h00) chk("type", {rsp.rtype, rsp.len}, {rt, rl});
      if (rl != 3'h0) chk("data", rsp.data, rd);
   endtask

   // Waits a few cycles for a key event and checks its bitmaps.
   task automatic look(input logic [5:0] p, input logic [5:0] r);
      logic [11:0] v;
      v = 12'h000;
      repeat (8) begin
         @(posedge clk_in);
         #1;
         if (evt.valid === 1'b1) v = {evt.press, evt.release_keys};
      end
      chk("event", v, {p, r});
   endtask

   // Main sequence.
   initial begin
      repeat (2) @(posedge clk_in);
      #1 nrst_in = 1'b1;
      keys = key_up_bit | key_south_bit;
      look(6'h21, 6'h00);
      xfer(8'h18, 3'h0, 32'h0, 8'h58, 3'h3, 40'h0000002121);
      keys = 6'h00;
      look(6'h00, 6'h21);
      xfer(8'h18, 3'h0, 32'h0, 8'h58, 3'h3, 40'h0000210000);
      xfer(8'h17, 3'h2, 32'h0010, 8'h57, 3'h0, 40'h0);
      keys = key_east_bit | key_west_bit;
      look(6'h10, 6'h00);
      keys = 6'h00;
      look(6'h00, 6'h00);
      xfer(8'h19, 3'h2, 32'h0200, 8'h00, 3'h0, 40'h0);
      xfer(8'h1a, 3'h4, 32'h04030201, 8'h5a, 3'h0, 40'h0);
      xfer(8'h19, 3'h2, 32'h0305, 8'h59, 3'h0, 40'h0);
      repeat (30) @(posedge clk_in);
      #1 pwr_wr = 4'h2;
      pwr_val = 8'h32;
      @(posedge clk_in);
      #1 pwr_wr = 4'h0;
      repeat (35) @(posedge clk_in);
      #1 chk("forced", forced, 4'h0);
      repeat (36) @(posedge clk_in);
      #1 chk("forced", forced, 4'h5);
      chk("pwm", {pwm[2], pwm[0]}, 2'h3);
      xfer(8'h1b, 3'h0, 32'h0, 8'h5b, 3'h5, 40'h0500643264);
      n0 = tach_hits;
      tach = 4'h1;
      repeat (8) @(posedge clk_in);
      #1 chk("tach", tach_hits - n0, 1);
      n0 = pwm3_hi;
      repeat (PWM_STEPS * 4) @(posedge clk_in);
      #1 chk("measure", pwm3_hi - n0, (8'h04 + FAN_MEAS_COUNTS) * 4);
      xfer(8'h17, 3'h2, 32'h0, 8'h57, 3'h0, 40'h0);
      keys = key_abort_bit;
      look(6'h00, 6'h00);
      xfer(8'h18, 3'h0, 32'h0, 8'h58, 3'h3, 40'h0000181c04);
      stop_test();
   end
endmodule
`default_nettype wire
